/* verilog/board_access_params.svh */
// constants for the board parameter access block: offsets, fields, timing
// assumes inclusion by every design file that needs a figure
`ifndef BOARD_ACCESS_PARAMS_SVH
`define BOARD_ACCESS_PARAMS_SVH
// register byte offsets on the wishbone slave
`define OFS_REQ      4'h0
`define OFS_DATA     4'h4
`define OFS_CMD      4'h8
`define OFS_STATUS   4'hC
// command bits
`define CMD_WRITE    0
`define CMD_READ     1
// status bits
`define ST_REPLY     0
`define ST_ARMED     1
`define ST_IGNORED   2
`define ST_BUSY      3
// request field width, all selection fields
`define FIELD_W      4
// channel 0 fixed identity bytes and status byte
`define B_DEV_ID     4'h0
`define B_SERIAL_LO  4'h1
`define B_SERIAL_HI  4'h2
`define B_STATUS     4'h3
// pulse generator parameter bytes
`define B_PG_WIDTH   4'h0
`define B_PG_AMP_LO  4'h1
`define B_PG_AMP_HI  4'h2
`define B_PG_ATT     4'h3
// pulse width unit and clock period
`define PG_UNIT_NS   100000
`define CLK_NS       20
`endif

/* verilog/board_access_pkg.sv */
// types shared by the board parameter access block
// assumes the params header is not needed here: types only
package board_access_pkg;
  // one request address: position, channel and byte within channel
  typedef struct packed {
    logic [3:0] tower;
    logic [3:0] rack;
    logic [3:0] board;
    logic [3:0] chan;
    logic [3:0] byte_addr;
  } req_t;
  // board position as read from the back plane straps
  typedef struct packed {
    logic [3:0] tower;
    logic [3:0] rack;
    logic [3:0] board;
  } pos_t;
endpackage : board_access_pkg

/* verilog/board_param_access.sv */
// board parameter access: decodes tower/rack/board/channel/byte requests,
// holds the byte parameters, guards protected channels, fires pulses
// assumes one 50 MHz clock, classic wishbone master, straps from back plane
`timescale 1ns/100ps
`include "board_access_params.svh"

// Summary of operation
// RULE_01: tower field spans 0 to 15
// RULE_02: rack field spans 0 to 15
// RULE_03: board field 0-15, own value from slot
// RULE_04: channel field spans 0 to 15
// RULE_05: byte address field spans 0 to 15
// RULE_06: one data byte per write or read
// RULE_07: protected channels execute only repeated writes
// RULE_08: pulses fire only on dedicated trigger
// RULE_09: four independent outputs, per-pulse amplitude, width
// RULE_10: channel 0 is virtual identity channel
// RULE_11: foreign position requests are silently ignored
// RULE_12: reads return last written unless status
module board_param_access
  import board_access_pkg::*;
#(
  parameter int          NCH       = 5,     // virtual channel plus units
  parameter logic [4:0]  PROT_MASK = 5'h00, // protected channels
  parameter int          PG_CH     = 1,     // pulse generator channel
  parameter logic [7:0]  DEV_ID    = 8'h5A, // arbitrary identity value
  parameter logic [15:0] SERIAL    = 16'h0001, // arbitrary serial value
  parameter int          PULSE_UNIT_CYC = `PG_UNIT_NS / `CLK_NS,
  parameter int          CW        = 24     // pulse counter width
)
(
  // clock, reset, enable
  input  wire logic        MCLK,
  input  wire logic        RST_N,
  input  wire logic        CE,
  // wishbone slave
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [3:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  // back plane position straps and trigger pin
  input  wire pos_t        POS,
  input  wire logic        TRIG,
  // pulse outputs
  output logic      [3:0]  PULSE_O,
  output logic      [11:0] PULSE_AMP,
  output logic      [7:0]  PULSE_ATT
);

  localparam int DEPTH = NCH * 16;

  // refuse sizes the decode cannot serve
  initial
  begin
    // the 7-bit storage index covers eight channels at most
    if (NCH < 2 || NCH > 8 || PG_CH < 1 || PG_CH >= NCH)
      $error("board_param_access: bad channel parameters");
    if (PULSE_UNIT_CYC < 1 || 255 * PULSE_UNIT_CYC >= (1 << CW))
      $error("board_param_access: pulse counter too narrow");
  end

  // ---------------- pin synchronisers ----------------
  logic [12:0] s1_q, s2_q, s3_q;  // three-stage chain, {trig, pos}
  logic [12:0] pin_q;             // accepted pin levels
  pos_t        own_pos;           // own tower, rack, slot
  logic        trig_q;            // accepted trigger level
  logic        trig_last_q;       // trigger level one cycle ago
  logic        trig_rise;         // trigger rising edge

  // pins are asynchronous; a change counts once stage 2 and 3 agree
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      s1_q  <= 13'h0000;
      s2_q  <= 13'h0000;
      s3_q  <= 13'h0000;
      pin_q <= 13'h0000;
    end
    else if (CE)
    begin
      s1_q <= {TRIG, POS};
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < 13; i++)
        if (s2_q[i] == s3_q[i])
          pin_q[i] <= s3_q[i];
    end
  end

  assign own_pos = pin_q[11:0];  // slot fixes board value, see RULE_03
  assign trig_q  = pin_q[12];

  // trigger edge detect on the filtered level only
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
      trig_last_q <= 1'b0;
    else if (CE)
      trig_last_q <= trig_q;
  end

  assign trig_rise = trig_q & ~trig_last_q;

  // ---------------- wishbone slave ----------------
  req_t        req_q;       // current request address
  logic [7:0]  data_q;      // write data byte
  logic [7:0]  reply_q;     // last read result
  logic        reply_vld_q; // read answered
  logic        ignored_q;   // last request was for another board
  logic        wr_go_q;     // execute write pulse
  logic        rd_go_q;     // execute read pulse
  logic        armed_q;     // first half of a protected write seen
  logic        bus_req;     // new wishbone access this cycle
  logic        bus_wr;      // new wishbone write this cycle
  logic [31:0] rd_mux;      // read data selection
  logic [3:0]  busy;        // per-output pulse active

  assign bus_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  assign bus_wr  = bus_req & WB_WE_I;

  // ack one cycle after the strobe, dropped the following cycle
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
      WB_ACK_O <= 1'b0;
    else if (CE)
      WB_ACK_O <= bus_req;
  end

  // register readback; unmapped offsets read as zero
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (WB_ADR_I)
      `OFS_REQ:    rd_mux = {12'h000, req_q};
      `OFS_DATA:   rd_mux = {24'h00_0000, data_q};
      `OFS_STATUS:
      begin
        rd_mux[15:8]        = reply_q;
        rd_mux[`ST_REPLY]   = reply_vld_q;
        rd_mux[`ST_ARMED]   = armed_q;
        rd_mux[`ST_IGNORED] = ignored_q;
        rd_mux[`ST_BUSY]    = |busy;
      end
      default:     rd_mux = 32'h0000_0000;
    endcase
  end

  // read data registered together with ack
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
      WB_DAT_O <= 32'h0000_0000;
    else if (CE && bus_req)
      WB_DAT_O <= rd_mux;
  end

  // request and data registers, byte lane writes
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      req_q  <= '0;
      data_q <= 8'h00;
    end
    else if (CE && bus_wr)
    begin
      if (WB_ADR_I == `OFS_REQ)
      begin
        // five 4-bit fields, each 0..15, see RULE_01 RULE_02 RULE_03
        // channel and byte fields, see RULE_04 RULE_05
        if (WB_SEL_I[0])
          req_q[7:0] <= WB_DAT_I[7:0];
        if (WB_SEL_I[1])
          req_q[15:8] <= WB_DAT_I[15:8];
        if (WB_SEL_I[2])
          req_q[19:16] <= WB_DAT_I[19:16];
      end
      if (WB_ADR_I == `OFS_DATA && WB_SEL_I[0])
        data_q <= WB_DAT_I[7:0];  // one byte per write, see RULE_06
    end
  end

  // command register produces one-cycle execute pulses
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      wr_go_q <= 1'b0;
      rd_go_q <= 1'b0;
    end
    else if (CE)
    begin
      wr_go_q <= bus_wr & (WB_ADR_I == `OFS_CMD) & WB_SEL_I[0]
                 & WB_DAT_I[`CMD_WRITE];
      rd_go_q <= bus_wr & (WB_ADR_I == `OFS_CMD) & WB_SEL_I[0]
                 & WB_DAT_I[`CMD_READ];
    end
  end

  // ---------------- request decode ----------------
  logic        match;      // request addresses this board
  logic        chan_ok;    // channel exists on this board
  logic        prot;       // channel is protected
  logic [6:0]  idx;        // parameter storage index
  logic        ro_byte;    // fixed identity byte
  logic        do_write;   // write actually executed
  req_t        key_req_q;  // address of the armed write
  logic [7:0]  key_data_q; // data of the armed write

  // foreign tower, rack or board: no store, no reply, see RULE_11
  assign match   = (req_q.tower == own_pos.tower)
                 & (req_q.rack  == own_pos.rack)
                 & (req_q.board == own_pos.board);
  assign chan_ok = 32'(req_q.chan) < NCH;
  assign prot    = chan_ok & PROT_MASK[req_q.chan[2:0]];
  assign idx     = 7'({req_q.chan, req_q.byte_addr});
  // channel 0 identity bytes cannot be overwritten, see RULE_10
  assign ro_byte = (req_q.chan == 4'h0) && (req_q.byte_addr <= `B_SERIAL_HI);

  // protected write runs only on the second identical command
  assign do_write = wr_go_q & match & chan_ok & ~ro_byte
                  & (~prot | (armed_q & key_req_q == req_q
                              & key_data_q == data_q)); // see RULE_07

  // arm and disarm the protected-write guard
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      armed_q    <= 1'b0;
      key_req_q  <= '0;
      key_data_q <= 8'h00;
    end
    else if (CE && wr_go_q && match)
    begin
      if (prot && !armed_q)
      begin
        // first copy only arms, see RULE_07
        armed_q    <= 1'b1;
        key_req_q  <= req_q;
        key_data_q <= data_q;
      end
      else if (prot && !do_write)
      begin
        // a different write restarts the pairing
        key_req_q  <= req_q;
        key_data_q <= data_q;
      end
      else
        armed_q <= 1'b0;
    end
  end

  // ---------------- parameter storage ----------------
  logic [7:0] mem_q [DEPTH];  // flip-flop byte store
  logic [6:0] pg_base;        // pulse generator channel base index
  logic [3:0] pg_en;          // output select and enable nibble
  logic       fire;           // trigger accepted with outputs enabled

  assign pg_base = 7'(PG_CH * 16);
  assign pg_en   = mem_q[pg_base + 7'(`B_PG_AMP_HI)][7:4];
  // firing needs the dedicated trigger input, see RULE_08
  assign fire    = trig_rise & (|pg_en);

  // stored bytes; enables are spent once a pulse fires
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_q[i] <= 8'h00;
    end
    else if (CE)
    begin
      if (do_write)
        mem_q[idx] <= data_q;  // see RULE_06
      // a new pulse needs reconfiguration and a new trigger
      if (fire)
        mem_q[pg_base + 7'(`B_PG_AMP_HI)][7:4] <= 4'h0;
    end
  end

  // ---------------- read path ----------------
  logic [7:0] rd_byte;  // selected byte for a read request

  // identity and status bytes override storage, see RULE_10 RULE_12
  always_comb
  begin
    rd_byte = mem_q[idx];  // last written value, see RULE_12
    if (req_q.chan == 4'h0)
    begin
      unique case (req_q.byte_addr)
        `B_DEV_ID:    rd_byte = DEV_ID;
        `B_SERIAL_LO: rd_byte = SERIAL[7:0];
        `B_SERIAL_HI: rd_byte = SERIAL[15:8];
        `B_STATUS:    rd_byte = {mem_q[idx][7:1], |busy};
        default:      rd_byte = mem_q[idx];
      endcase
    end
  end

  // reply and ignore flags follow each executed command
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      reply_q     <= 8'h00;
      reply_vld_q <= 1'b0;
      ignored_q   <= 1'b0;
    end
    else if (CE && (wr_go_q || rd_go_q))
    begin
      ignored_q   <= ~match;           // see RULE_11
      reply_vld_q <= rd_go_q & match & chan_ok;
      if (rd_go_q && match && chan_ok)
        reply_q <= rd_byte;            // one byte back, see RULE_06
    end
  end

  // ---------------- pulse outputs ----------------
  logic [7:0] pg_width;  // width in 100 us units

  assign pg_width = mem_q[pg_base + 7'(`B_PG_WIDTH)];

  // amplitude and attenuation latched per pulse, see RULE_09
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      PULSE_AMP <= 12'h000;
      PULSE_ATT <= 8'h00;
    end
    else if (CE && fire)
    begin
      PULSE_AMP <= {mem_q[pg_base + 7'(`B_PG_AMP_HI)][3:0],
                    mem_q[pg_base + 7'(`B_PG_AMP_LO)]};
      PULSE_ATT <= mem_q[pg_base + 7'(`B_PG_ATT)];
    end
  end

  // four outputs started by the same fire, each with its own timer, see RULE_09
  for (genvar g = 0; g < 4; g++)
  begin : g_out
    logic [CW-1:0] cnt_q;  // cycles left in this output's pulse

    always_ff @(posedge MCLK)
    begin
      if (!RST_N)
      begin
        cnt_q      <= '0;
        PULSE_O[g] <= 1'b0;
      end
      else if (CE)
      begin
        if (fire && pg_en[g] && pg_width != 8'h00)
        begin
          cnt_q      <= CW'(32'(pg_width) * PULSE_UNIT_CYC);
          PULSE_O[g] <= 1'b1;  // see RULE_08
        end
        else if (cnt_q > CW'(1))
          cnt_q <= cnt_q - CW'(1);
        else
        begin
          cnt_q      <= '0;
          PULSE_O[g] <= 1'b0;
        end
      end
    end

    assign busy[g] = PULSE_O[g];
  end

endmodule : board_param_access

/* tb/board_param_checker.sv */
// checker: bus answer timing and pulse firing of the parameter access block
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/100ps
module board_param_checker
  import board_access_pkg::*;
(
  // clock, reset, enable
  input wire logic        MCLK,
  input wire logic        RST_N,
  input wire logic        CE,
  // wishbone slave
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_WE_I,
  input wire logic [3:0]  WB_ADR_I,
  input wire logic [3:0]  WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic        WB_ACK_O,
  // straps and trigger
  input wire pos_t        POS,
  input wire logic        TRIG,
  // pulse outputs
  input wire logic [3:0]  PULSE_O,
  input wire logic [11:0] PULSE_AMP,
  input wire logic [7:0]  PULSE_ATT
);
  logic       take;        // request taken at this edge
  logic [3:0] trig_age_q;  // cycles since trigger was last high
  assign take = WB_CYC_I && WB_STB_I && !WB_ACK_O && CE;
  // saturating age; starts saturated so reset never looks like a trigger
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
      trig_age_q <= 4'hF;
    else if (TRIG)
      trig_age_q <= 4'h0;
    else if (trig_age_q != 4'hF)
      trig_age_q <= trig_age_q + 4'h1;
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  ack_one_cycle_a: assert property
    (WB_ACK_O |=> !WB_ACK_O) else $error("ack held too long");
  ack_next_a: assert property
    (take |=> WB_ACK_O) else $error("request not answered");
  ack_cause_a: assert property
    ($rose(WB_ACK_O) |-> $past(take)) else $error("ack without request");
  fire_after_trig_a: assert property
    ($rose(|PULSE_O) |-> trig_age_q < 4'hA)
    else $error("pulse without trigger");
  amp_on_fire_a: assert property
    (!$stable(PULSE_AMP) |-> trig_age_q < 4'hA)
    else $error("amplitude moved without trigger");
  att_on_fire_a: assert property
    (!$stable(PULSE_ATT) |-> trig_age_q < 4'hA)
    else $error("attenuation moved without trigger");
  unmapped_zero_a: assert property
    (take && !WB_WE_I && (WB_ADR_I[1:0] != 2'h0 || WB_ADR_I == 4'h8)
     |=> WB_DAT_O == 32'h0) else $error("unmapped read not zero");
  ce_freeze_a: assert property
    (!CE |=> $stable(PULSE_O) && $stable(WB_ACK_O))
    else $error("state moved with enable low");
  fire_c: cover property ($rose(|PULSE_O));
  wr_c: cover property (take && WB_WE_I);
  rd_c: cover property (take && !WB_WE_I);
endmodule : board_param_checker

bind board_param_access board_param_checker u_board_param_checker (
  .MCLK(MCLK), .RST_N(RST_N), .CE(CE), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
  .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
  .WB_ACK_O(WB_ACK_O), .POS(POS), .TRIG(TRIG), .PULSE_O(PULSE_O),
  .PULSE_AMP(PULSE_AMP), .PULSE_ATT(PULSE_ATT));

/* tb/trig_source.sv */
// trigger source model: the far-side shot that fires the pulse generator
// assumes go is a one-cycle request, dly the wait before the shot
`timescale 1ns/100ps
module trig_source
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // request from the bench
  input  wire logic       go,
  input  wire logic [3:0] dly,
  // trigger line, idles low between shots
  output logic            trig
);
  logic [4:0] cnt_q;  // wait plus high time left
  // countdown; the last four counts hold the line high
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      cnt_q <= 5'h00;
    else if (go)
      cnt_q <= {1'b0, dly} + 5'h04;
    else if (cnt_q != 5'h00)
      cnt_q <= cnt_q - 5'h01;
  end
  // only a requested shot raises the line, never the bus
  assign trig = (cnt_q != 5'h00) && (cnt_q <= 5'h04);
endmodule : trig_source

/* tb/tb_board_param_access.sv */
// bench: byte model against the block over wishbone, plus one pulse shot
// assumes package, header, design, checker and trigger model compiled first
`timescale 1ns/100ps
module tb_board_param_access import board_access_pkg::*;;
  logic        mclk, rst_n, ce, cyc, stb, we, go, trig;  // bench drives; trig comes from the trigger model
  logic        ack;            // bus answer
  logic [3:0]  adr, dly, pulse;
  logic [31:0] wdat, rdat, st; // st: last read data
  logic [11:0] amp;
  logic [7:0]  att;
  pos_t        pos;            // straps, one random value drawn after the fixed seed
  int          bad_count, n_checks;
  int          mem [int];      // model: last byte per chan*16+byte
  // protected channel 2, short pulse unit to keep the run brief
  board_param_access #(.PROT_MASK(5'h04), .PULSE_UNIT_CYC(2))
    u_board_param_access (.MCLK(mclk), .RST_N(rst_n), .CE(ce),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .POS(pos), .TRIG(trig), .PULSE_O(pulse), .PULSE_AMP(amp),
    .PULSE_ATT(att));
  trig_source u_trig_source (.clk(mclk), .rst_n(rst_n), .go(go),
    .dly(dly), .trig(trig));
  // 50 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // verdict and end of run
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize
  // the one compare of any result value
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // one classic cycle; entered just after a rising edge
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    st = rdat;
    if (n >= 20)
    begin
      bad_count++;
      summarize;
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge mclk);
  endtask : wb
  // request, optional data, command, then status read into st
  task automatic access(input logic w, input pos_t p, input int c,
                        input int b, input logic [7:0] d);
    req_t r;
    r = {p, c[3:0], b[3:0]};
    wb(1'b1, 4'h0, {12'h0, r});
    if (w)
      wb(1'b1, 4'h4, {24'h0, d});
    wb(1'b1, 4'h8, {30'h0, !w, w});
    wb(1'b0, 4'hC, 32'h0);
  endtask : access
  // model byte, zero until written
  function automatic logic [7:0] ref_byte(input int c, input int b);
    return mem.exists(c * 16 + b) ? mem[c * 16 + b][7:0] : 8'h00;
  endfunction : ref_byte
  // main sequence
  initial
  begin
    int         c, b, n;
    logic [7:0] d;
    {rst_n, cyc, stb, we, go, adr, dly, wdat} = '0;
    ce = 1'b1;
    bad_count = 0;
    n_checks = 0;
    void'($urandom(32'h2C78));
    pos = pos_t'($urandom);
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (6) @(posedge mclk);
    // identity byte 0 of the virtual channel ignores a write, bytes 0 to 2 read fixed
    access(1'b1, pos, 0, 0, 8'hFF);
    for (b = 0; b < 3; b++)
    begin
      access(1'b0, pos, 0, b, 8'h00);
      chk(st[15:0], {(b == 0) ? 8'h5A : {7'h0, b == 1}, 8'h01});
    end
    $display("test ident done");
    // random bytes on units 1, 3, 4; model holds last write
    for (int i = 0; i < 24; i++)
    begin
      c = 1 + $urandom_range(0, 2);
      c = (c == 2) ? 4 : c;
      b = $urandom_range(0, 15);
      d = $urandom;
      if ($urandom_range(0, 1))
      begin
        access(1'b1, pos, c, b, d);
        mem[c * 16 + b] = d;
      end
      access(1'b0, pos, c, b, 8'h00);
      chk(st[15:0], {ref_byte(c, b), 8'h01});
    end
    $display("test bytes done");
    // a foreign tower, rack or board is ignored and stores nothing
    for (int k = 0; k < 3; k++)
    begin
      access(1'b1, pos_t'(pos ^ (12'h1 << (4 * k))), 3, 5, ~ref_byte(3, 5));
      chk({st[2], st[0]}, 16'h2);
      access(1'b0, pos, 3, 5, 8'h00);
      chk(st[15:8], ref_byte(3, 5));
    end
    // channels past the last unit give no reply
    access(1'b0, pos, 5, 0, 8'h00);
    chk(st[0], 1'b0);
    access(1'b0, pos, 15, 0, 8'h00);
    chk(st[0], 1'b0);
    $display("test decode done");
    // protected unit: first write arms only, a read keeps it armed
    d = $urandom;
    access(1'b1, pos, 2, 7, d);
    access(1'b0, pos, 2, 7, 8'h00);
    chk({st[15:8], st[1]}, 16'h1);
    access(1'b1, pos, 2, 7, d);
    access(1'b0, pos, 2, 7, 8'h00);
    chk({st[15:8], st[1]}, {d, 1'b0});
    $display("test protect done");
    // pulse: width 3, outputs 0 and 2, random amplitude and attenuation
    mem[16] = 3;
    mem[17] = $urandom;
    mem[18] = {4'h5, 4'($urandom)};
    mem[19] = $urandom;
    for (b = 0; b < 4; b++)
      access(1'b1, pos, 1, b, ref_byte(1, b));
    repeat (20) @(posedge mclk);
    chk(pulse, 4'h0);
    ce <= 1'b0;
    repeat (3) @(posedge mclk);
    ce <= 1'b1;
    go <= 1'b1;
    dly <= 4'($urandom);
    @(posedge mclk);
    go <= 1'b0;
    n = 0;
    while (pulse === 4'h0 && n < 60)
    begin
      @(posedge mclk);
      n++;
    end
    if (n >= 60)
    begin
      bad_count++;
      summarize;
    end
    chk(pulse, 4'h5);
    d = ref_byte(1, 2);
    chk(16'(amp), {4'h0, d[3:0], ref_byte(1, 1)});
    chk(16'(att), 16'(ref_byte(1, 3)));
    n = 0;
    while (pulse[0] === 1'b1 && n < 50)
    begin
      n++;
      @(posedge mclk);
    end
    if (n >= 50)
    begin
      bad_count++;
      summarize;
    end
    chk(16'(n), 16'd6);
    // enables are spent at fire, only the amplitude nibble stays
    mem[18] = {4'h0, d[3:0]};
    access(1'b0, pos, 1, 2, 8'h00);
    chk(st[15:8], {4'h0, d[3:0]});
    $display("test pulse done");
    // unmapped offset and the write-only command read as zero
    wb(1'b0, 4'h2, 32'h0);
    chk(st[15:0], 16'h0);
    wb(1'b0, 4'h8, 32'h0);
    chk(st[15:0], 16'h0);
    $display("test unmapped done");
    summarize;
  end
endmodule : tb_board_param_access
